// ### verilog/exec_pkg.sv
// Shared constants and types for the instruction execution core.
// Assumes a single clock domain and synchronous active-high reset.
package exec_pkg;
	// ==========================================================
	// Timing
	localparam int unsigned SYS_PER_ICYCLE = 4;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [1:0] PHASE_RESET = 2'h0;
	// ==========================================================
	// Widths and reset values
	localparam int unsigned PC_W = 11;
	localparam int unsigned STACK_DEPTH = 4;
	localparam logic [10:0] PC_RESET = 11'h000;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [6:0] DADDR_PCL = 7'h02;
	localparam logic [1:0] SP_RESET = 2'h0;
	// ==========================================================
	// Operation classes
	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_MOV_MA = 5'h01, OP_MOV_AM = 5'h02, OP_MOV_IA = 5'h03,
		OP_ADD = 5'h04, OP_SUB = 5'h05, OP_AND = 5'h06, OP_OR = 5'h07,
		OP_XOR = 5'h08, OP_CPL = 5'h09, OP_INC = 5'h0A, OP_DEC = 5'h0B,
		OP_RR = 5'h0C, OP_RL = 5'h0D, OP_RRC = 5'h0E, OP_RLC = 5'h0F,
		OP_BSET = 5'h10, OP_BCLR = 5'h11, OP_JMP = 5'h12, OP_CALL = 5'h13,
		OP_RET = 5'h14, OP_INTERRUPT_EXIT = 5'h15, OP_TABRD = 5'h16, OP_SZ = 5'h17,
		OP_SNZ = 5'h18, OP_SZB = 5'h19, OP_SNZB = 5'h1A, OP_CLR = 5'h1B
	} op_e;
	// Decoded instruction
	typedef struct packed {
		op_e op;
		logic to_acc;
		logic [6:0] maddr;
		logic [7:0] imm;
		logic [2:0] bit_sel;
		logic [10:0] target;
	} instr_s;
	// Flag set
	typedef struct packed {
		logic carry;
		logic zero;
	} flags_s;
endpackage

// ### verilog/exec_phase.sv
// Instruction cycle phase counter: divides the system clock by four.
// Assumes the same clock and reset as the core.
`timescale 1ns/10ps
`default_nettype none
module exec_phase (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// Phase
	output logic [1:0] phase_out,
	output logic last_out
);
	logic [1:0] phase_r;
	// ==========================================================
	// Phase count, wraps every instruction cycle
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			phase_r <= exec_pkg::PHASE_RESET;
		end else begin
			phase_r <= phase_r + 2'h1;
		end
	end
	assign phase_out = phase_r;
	assign last_out = (phase_r == exec_pkg::PHASE_LAST);
endmodule // exec_phase
`default_nettype wire

// ### verilog/exec_core.sv
// Instruction execution core: decodes an externally fetched instruction each
// instruction cycle and updates PC, accumulator, flags and data memory.
// Assumes program memory answers instr_in combinationally for pc_out.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - One instruction cycle is four system clocks and all execution advances in those units.
// - Ordinary instructions take one cycle; jump, call, return, interrupt return and table read take two.
// - Writing the program counter low byte causes a jump and costs one extra cycle.
// - A skip instruction takes one cycle, plus one more when the skip is taken.
// - Conditional branches test a memory byte or bit and either continue or skip the next instruction.
// - Call saves the next address, return resumes there, and jump saves nothing.
// - Add reports carry above 255 and subtract reports borrow below zero.
// - Increment and decrement change the operand by exactly one, to memory or accumulator.
// - Logical operations set the zero flag when the result is zero.
// - Data goes through the accumulator, with memory-to-acc, acc-to-memory and immediate moves.
// - Rotates move one bit left or right, through-carry forms put the shifted bit in carry.
// - Bit set and clear change only the addressed bit using an internal read-modify-write.
// - Programming-time options are fixed and cannot be changed by the program.
module exec_core #(
	parameter int unsigned DMEM_DEPTH = 80,
	parameter logic [7:0] OPTION_BITS = 8'h00
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// Instruction fetch
	input wire exec_pkg::instr_s instr_in,
	output logic [10:0] pc_out,
	// Table read data from program memory at the accumulator-selected address
	input wire logic [7:0] table_data_in,
	// State views
	output logic [7:0] acc_out,
	output exec_pkg::flags_s flags_out,
	output logic [7:0] options_out,
	output logic icycle_out,
	output logic flush_out
);
	// ==========================================================
	// State
	logic [1:0] phase;
	logic last;
	logic [10:0] pc_r, pc_nxt;
	logic [7:0] acc_r, acc_nxt;
	exec_pkg::flags_s flags_r, flags_nxt;
	logic flush_r, flush_nxt;
	logic [1:0] sp_r;
	logic [10:0] stack_r [exec_pkg::STACK_DEPTH];
	logic [7:0] dmem_r [DMEM_DEPTH];
	logic [7:0] options_r;
	logic icycle_r;
	exec_phase u_phase (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.phase_out(phase),
		.last_out(last)
	);
	// ==========================================================
	// Decode
	exec_pkg::instr_s ins;
	wire [7:0] mval = (instr_in.maddr == exec_pkg::DADDR_PCL) ? pc_r[7:0] : dmem_r[instr_in.maddr];
	wire [10:0] pc_inc = pc_r + 11'h001;
	wire [10:0] pc_skip = pc_r + 11'h002;
	wire [8:0] sum9 = {1'b0, acc_r} + {1'b0, mval};
	wire [8:0] dif9 = {1'b0, acc_r} - {1'b0, mval};
	wire [7:0] bit_mask = 8'h01 << instr_in.bit_sel;
	wire bit_val = |(mval & bit_mask);
	logic [7:0] res;
	logic wr_mem, wr_acc, set_z, set_c, new_c, skip, jump, pcl_wr;
	assign ins = flush_r ? '0 : instr_in;
	// Result and control per operation
	always_comb begin
		res = 8'h00;
		wr_mem = 1'b0;
		wr_acc = 1'b0;
		set_z = 1'b0;
		set_c = 1'b0;
		new_c = flags_r.carry;
		skip = 1'b0;
		jump = 1'b0;
		case (ins.op)
			exec_pkg::OP_MOV_MA: begin res = mval; wr_acc = 1'b1; end
			exec_pkg::OP_MOV_AM: begin res = acc_r; wr_mem = 1'b1; end
			exec_pkg::OP_MOV_IA: begin res = ins.imm; wr_acc = 1'b1; end
			exec_pkg::OP_ADD: begin res = sum9[7:0]; wr_acc = 1'b1; set_z = 1'b1; set_c = 1'b1; new_c = sum9[8]; end
			exec_pkg::OP_SUB: begin res = dif9[7:0]; wr_acc = 1'b1; set_z = 1'b1; set_c = 1'b1; new_c = dif9[8]; end
			exec_pkg::OP_AND: begin res = acc_r & mval; wr_acc = 1'b1; set_z = 1'b1; end
			exec_pkg::OP_OR: begin res = acc_r | mval; wr_acc = 1'b1; set_z = 1'b1; end
			exec_pkg::OP_XOR: begin res = acc_r ^ mval; wr_acc = 1'b1; set_z = 1'b1; end
			exec_pkg::OP_CPL: begin res = ~mval; wr_acc = ins.to_acc; wr_mem = !ins.to_acc; set_z = 1'b1; end
			exec_pkg::OP_INC: begin res = mval + 8'h01; wr_acc = ins.to_acc; wr_mem = !ins.to_acc; set_z = 1'b1; end
			exec_pkg::OP_DEC: begin res = mval - 8'h01; wr_acc = ins.to_acc; wr_mem = !ins.to_acc; set_z = 1'b1; end
			exec_pkg::OP_RR: begin res = {mval[0], mval[7:1]}; wr_acc = ins.to_acc; wr_mem = !ins.to_acc; end
			exec_pkg::OP_RL: begin res = {mval[6:0], mval[7]}; wr_acc = ins.to_acc; wr_mem = !ins.to_acc; end
			exec_pkg::OP_RRC: begin
				res = {flags_r.carry, mval[7:1]};
				wr_acc = ins.to_acc;
				wr_mem = !ins.to_acc;
				set_c = 1'b1;
				new_c = mval[0];
			end
			exec_pkg::OP_RLC: begin
				res = {mval[6:0], flags_r.carry};
				wr_acc = ins.to_acc;
				wr_mem = !ins.to_acc;
				set_c = 1'b1;
				new_c = mval[7];
			end
			exec_pkg::OP_BSET: begin res = mval | bit_mask; wr_mem = 1'b1; end
			exec_pkg::OP_BCLR: begin res = mval & ~bit_mask; wr_mem = 1'b1; end
			exec_pkg::OP_CLR: begin res = 8'h00; wr_mem = 1'b1; end
			exec_pkg::OP_JMP, exec_pkg::OP_CALL, exec_pkg::OP_RET, exec_pkg::OP_INTERRUPT_EXIT: jump = 1'b1;
			exec_pkg::OP_TABRD: begin res = table_data_in; wr_acc = 1'b1; jump = 1'b1; end
			exec_pkg::OP_SZ: skip = (mval == 8'h00);
			exec_pkg::OP_SNZ: skip = (mval != 8'h00);
			exec_pkg::OP_SZB: skip = !bit_val;
			exec_pkg::OP_SNZB: skip = bit_val;
			default: ;
		endcase
	end
	assign pcl_wr = wr_mem && (ins.maddr == exec_pkg::DADDR_PCL);
	// Next state
	always_comb begin
		// A discarded slot holds the PC so the target it fetched runs next cycle
		pc_nxt = flush_r ? pc_r : pc_inc;
		acc_nxt = wr_acc ? res : acc_r;
		flags_nxt.zero = set_z ? (res == 8'h00) : flags_r.zero;
		flags_nxt.carry = set_c ? new_c : flags_r.carry;
		flush_nxt = 1'b0;
		if (ins.op == exec_pkg::OP_JMP || ins.op == exec_pkg::OP_CALL) begin
			pc_nxt = ins.target;
		end else if (ins.op == exec_pkg::OP_RET || ins.op == exec_pkg::OP_INTERRUPT_EXIT) begin
			pc_nxt = stack_r[sp_r - 2'h1];
		end else if (pcl_wr) begin
			pc_nxt = {pc_r[10:8], res};
		end else if (skip) begin
			pc_nxt = pc_skip;
		end
		// Table read keeps the PC flowing; its second cycle is the dummy slot
		if (jump || pcl_wr || skip) begin
			flush_nxt = 1'b1;
		end
		if (ins.op == exec_pkg::OP_TABRD) begin
			pc_nxt = pc_inc;
		end
	end
	// ==========================================================
	// Registers, updated on the last phase only, except icycle_r which follows last every clock
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			pc_r <= exec_pkg::PC_RESET;
			acc_r <= exec_pkg::ACC_RESET;
			flags_r <= '0;
			flush_r <= 1'b0;
			sp_r <= exec_pkg::SP_RESET;
			icycle_r <= 1'b0;
		end else begin
			icycle_r <= last;
			if (last) begin
				pc_r <= pc_nxt;
				acc_r <= acc_nxt;
				flags_r <= flags_nxt;
				flush_r <= flush_nxt;
				if (ins.op == exec_pkg::OP_CALL) begin
					stack_r[sp_r] <= pc_inc;
					sp_r <= sp_r + 2'h1;
				end else if (ins.op == exec_pkg::OP_RET || ins.op == exec_pkg::OP_INTERRUPT_EXIT) begin
					sp_r <= sp_r - 2'h1;
				end
				if (wr_mem && !pcl_wr) begin
					dmem_r[ins.maddr] <= res;
				end
			end
		end
	end
	// Options are reloaded from OPTION_BITS every clock; no instruction path writes them
	always_ff @(posedge clock_in) begin
		options_r <= OPTION_BITS;
	end
	assign pc_out = pc_r;
	assign acc_out = acc_r;
	assign flags_out = flags_r;
	assign options_out = options_r;
	assign icycle_out = icycle_r;
	assign flush_out = flush_r;
	// ==========================================================
	// Assertions
	property p_phase_wrap;
		@(posedge clock_in) disable iff (rst_in) last |=> !last [*3] ##1 last;
	endproperty
	a_phase_wrap: assert property (p_phase_wrap) else $error("phase not four clocks");
	property p_jump_flush;
		@(posedge clock_in) disable iff (rst_in) (last && ins.op == exec_pkg::OP_JMP) |=> flush_r && pc_r == $past(ins.target);
	endproperty
	a_jump_flush: assert property (p_jump_flush) else $error("jump not two cycles");
	property p_pcl_flush;
		@(posedge clock_in) disable iff (rst_in) (last && pcl_wr) |=> flush_r;
	endproperty
	a_pcl_flush: assert property (p_pcl_flush) else $error("pcl write no extra cycle");
	property p_skip;
		@(posedge clock_in) disable iff (rst_in) (last && skip) |=> flush_r && pc_r == $past(pc_r) + 11'h002;
	endproperty
	a_skip: assert property (p_skip) else $error("skip wrong");
	property p_noskip;
		@(posedge clock_in) disable iff (rst_in) (last && ins.op == exec_pkg::OP_SZ && !skip) |=> !flush_r;
	endproperty
	a_noskip: assert property (p_noskip) else $error("untaken skip flushed");
	property p_add_carry;
		@(posedge clock_in) disable iff (rst_in) (last && ins.op == exec_pkg::OP_ADD) |=>
			flags_r.carry == (({1'b0, $past(acc_r)} + {1'b0, $past(mval)}) > 9'h0FF);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("carry wrong");
	property p_inc_acc;
		@(posedge clock_in) disable iff (rst_in) (last && ins.op == exec_pkg::OP_INC && ins.to_acc) |=> acc_r == $past(mval) + 8'h01;
	endproperty
	a_inc_acc: assert property (p_inc_acc) else $error("increment wrong");
	property p_logic_zero;
		@(posedge clock_in) disable iff (rst_in) (last && ins.op == exec_pkg::OP_AND) |=>
			flags_r.zero == (($past(acc_r) & $past(mval)) == 8'h00);
	endproperty
	a_logic_zero: assert property (p_logic_zero) else $error("zero flag wrong");
	property p_flush_hold;
		@(posedge clock_in) disable iff (rst_in) (last && flush_r) |=>
			!flush_r && pc_r == $past(pc_r) && $stable(acc_r) && $stable(flags_r);
	endproperty
	a_flush_hold: assert property (p_flush_hold) else $error("flushed slot executed");
endmodule // exec_core
`default_nettype wire

// ### tb/mcu_instruction_execution_timing_tb.sv
// Self-checking bench for the execution core: presents one decoded instruction per slot.
// Assumes the bench plays program memory and holds instr_in for the whole slot.
`timescale 1ns/10ps
`default_nettype none
module mcu_instruction_execution_timing_tb;
	// ==========================================================
	// Clock, stimulus and counters
	localparam logic [7:0] OPTS = 8'hA5;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	exec_pkg::instr_s ins = '0;
	logic [7:0] tbl = 8'h00;
	logic [10:0] pc_v;
	logic [7:0] acc_v;
	exec_pkg::flags_s fl_v;
	logic [7:0] opt_v;
	logic icyc_v;
	logic fsh_v;
	int n_mismatch = 0;
	int comparisons = 0;
	always #12.5 clock_in = ~clock_in;
	// Core under test, options fixed at build time
	exec_core #(.OPTION_BITS(OPTS)) exec_core_i (.clock_in(clock_in), .rst_in(rst_in), .instr_in(ins),
		.pc_out(pc_v), .table_data_in(tbl), .acc_out(acc_v), .flags_out(fl_v), .options_out(opt_v),
		.icycle_out(icyc_v), .flush_out(fsh_v));
	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
		comparisons++;
		if (e !== g) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Wait for the slot marker; a bounded wait so a dead core cannot hang the run
	task automatic slot(output int n);
		n = 0;
		do begin
			@(posedge clock_in);
			#1;
			n++;
		end while (icyc_v !== 1'b1 && n < 9);
		if (icyc_v !== 1'b1) begin
			chk("slot wait", 11'h000, 11'h001);
			give_verdict();
		end
	endtask
	task automatic x(input exec_pkg::op_e o, input logic t = 1'b1, input logic [6:0] m = 7'h00,
		input logic [7:0] v = 8'h00, input logic [2:0] b = 3'h0, input logic [10:0] a = 11'h000);
		int n;
		ins = '{o, t, m, v, b, a};
		slot(n);
		chk("slot length", 11'h004, 11'(n));
	endtask
	task automatic put(input logic [6:0] m, input logic [7:0] v);
		x(exec_pkg::OP_MOV_IA, 1'b1, 7'h00, v);
		x(exec_pkg::OP_MOV_AM, 1'b1, m);
	endtask
	// Branch, then check the new PC and the discarded slot that follows
	task automatic br(input exec_pkg::op_e o, input logic [10:0] a, input logic [10:0] epc);
		x(o, 1'b1, 7'h00, 8'h00, 3'h0, a);
		chk("branch pc", epc, pc_v);
		chk("branch flush", 11'h001, fsh_v);
		x(exec_pkg::OP_NOP);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		int n;
		repeat (12) @(posedge clock_in);
		#1;
		chk("reset pc", 11'h000, pc_v);
		chk("reset acc", 11'h000, acc_v);
		rst_in = 1'b0;
		slot(n);
		chk("first pc", 11'h001, pc_v);
		chk("options", OPTS, opt_v);
	endtask
	task automatic t_alu();
		put(7'h10, 8'h80);
		x(exec_pkg::OP_MOV_IA, 1'b1, 7'h00, 8'h90);
		x(exec_pkg::OP_ADD, 1'b1, 7'h10, 8'h80);
		chk("add sum", 11'h010, acc_v);
		chk("add carry", 11'h001, fl_v.carry);
		chk("add flush", 11'h000, fsh_v);
		x(exec_pkg::OP_SUB, 1'b1, 7'h10, 8'h80);
		chk("sub borrow", 11'h001, fl_v.carry);
		x(exec_pkg::OP_SUB, 1'b1, 7'h10, 8'h80);
		chk("sub diff", 11'h010, acc_v);
		chk("sub no borrow", 11'h000, fl_v.carry);
		x(exec_pkg::OP_MOV_MA, 1'b1, 7'h10);
		chk("mem to acc", 11'h080, acc_v);
	endtask
	task automatic t_incdec();
		put(7'h11, 8'hFF);
		x(exec_pkg::OP_INC, 1'b1, 7'h11);
		chk("inc to acc", 11'h000, acc_v);
		x(exec_pkg::OP_DEC, 1'b0, 7'h11);
		x(exec_pkg::OP_MOV_MA, 1'b1, 7'h11);
		chk("dec to mem", 11'h0FE, acc_v);
		x(exec_pkg::OP_DEC, 1'b1, 7'h11);
		chk("dec to acc", 11'h0FD, acc_v);
		x(exec_pkg::OP_INC, 1'b0, 7'h11);
		x(exec_pkg::OP_MOV_MA, 1'b1, 7'h11);
		chk("inc to mem", 11'h0FF, acc_v);
	endtask
	task automatic t_logic();
		put(7'h12, 8'h0F);
		x(exec_pkg::OP_MOV_IA, 1'b1, 7'h00, 8'hF0);
		x(exec_pkg::OP_AND, 1'b1, 7'h12, 8'h0F);
		chk("and zero", 11'h001, fl_v.zero);
		x(exec_pkg::OP_OR, 1'b1, 7'h12, 8'h0F);
		chk("or nonzero", 11'h000, fl_v.zero);
		x(exec_pkg::OP_XOR, 1'b1, 7'h12, 8'h0F);
		chk("xor zero", 11'h001, fl_v.zero);
		x(exec_pkg::OP_CPL, 1'b1, 7'h12);
		chk("cpl value", 11'h0F0, acc_v);
	endtask
	// Carry is cleared first by an add that cannot overflow
	task automatic t_rot();
		put(7'h13, 8'h81);
		x(exec_pkg::OP_MOV_IA);
		x(exec_pkg::OP_ADD, 1'b1, 7'h13, 8'h81);
		x(exec_pkg::OP_RR, 1'b1, 7'h13);
		chk("rr", 11'h0C0, acc_v);
		x(exec_pkg::OP_RL, 1'b1, 7'h13);
		chk("rl", 11'h003, acc_v);
		x(exec_pkg::OP_RRC, 1'b1, 7'h13);
		chk("rrc", 11'h040, acc_v);
		chk("rrc carry", 11'h001, fl_v.carry);
		x(exec_pkg::OP_RLC, 1'b1, 7'h13);
		chk("rlc", 11'h003, acc_v);
		x(exec_pkg::OP_RR, 1'b0, 7'h13);
		x(exec_pkg::OP_MOV_MA, 1'b1, 7'h13);
		chk("rr to mem", 11'h0C0, acc_v);
		chk("rr keeps carry", 11'h001, fl_v.carry);
	endtask
	task automatic t_bits();
		put(7'h14, 8'h5A);
		x(exec_pkg::OP_BSET, 1'b1, 7'h14, 8'h00, 3'h0);
		x(exec_pkg::OP_MOV_MA, 1'b1, 7'h14);
		chk("bit set", 11'h05B, acc_v);
		x(exec_pkg::OP_BCLR, 1'b1, 7'h14, 8'h00, 3'h6);
		x(exec_pkg::OP_MOV_MA, 1'b1, 7'h14);
		chk("bit clear", 11'h01B, acc_v);
	endtask
	task automatic t_flow();
		x(exec_pkg::OP_MOV_IA, 1'b1, 7'h00, 8'h33);
		x(exec_pkg::OP_JMP, 1'b1, 7'h00, 8'h00, 3'h0, 11'h100);
		x(exec_pkg::OP_MOV_IA, 1'b1, 7'h00, 8'h77);
		chk("discarded slot", 11'h033, acc_v);
		chk("flush ends", 11'h000, fsh_v);
		br(exec_pkg::OP_CALL, 11'h200, 11'h200);
		br(exec_pkg::OP_RET, 11'h000, 11'h101);
		br(exec_pkg::OP_CALL, 11'h300, 11'h300);
		br(exec_pkg::OP_INTERRUPT_EXIT, 11'h000, 11'h102);
		tbl = 8'h3C;
		br(exec_pkg::OP_TABRD, 11'h000, 11'h103);
		chk("table data", 11'h03C, acc_v);
	endtask
	task automatic t_skip();
		exec_pkg::op_e ops [6] = '{exec_pkg::OP_SZ, exec_pkg::OP_SNZ, exec_pkg::OP_SZ,
			exec_pkg::OP_SNZ, exec_pkg::OP_SZB, exec_pkg::OP_SNZB};
		logic [5:0] sk = 6'b101001;
		logic [10:0] p = 11'h040;
		put(7'h15, 8'h00);
		put(7'h16, 8'h04);
		br(exec_pkg::OP_JMP, 11'h040, 11'h040);
		for (int i = 0; i < 6; i++) begin
			x(ops[i], 1'b1, (i < 2) ? 7'h15 : 7'h16, 8'h00, 3'h2);
			p = p + (sk[i] ? 11'h002 : 11'h001);
			chk("skip pc", p, pc_v);
			chk("skip flush", {10'h000, sk[i]}, fsh_v);
			if (sk[i]) x(exec_pkg::OP_NOP);
		end
	endtask
	task automatic t_pcl();
		br(exec_pkg::OP_JMP, 11'h140, 11'h140);
		x(exec_pkg::OP_MOV_IA, 1'b1, 7'h00, 8'h60);
		x(exec_pkg::OP_MOV_AM, 1'b1, exec_pkg::DADDR_PCL);
		chk("pcl move", 11'h160, pc_v);
		chk("pcl move flush", 11'h001, fsh_v);
		x(exec_pkg::OP_NOP);
		x(exec_pkg::OP_CLR, 1'b1, exec_pkg::DADDR_PCL);
		chk("pcl clear", 11'h100, pc_v);
		chk("pcl clear flush", 11'h001, fsh_v);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		t_reset();
		t_alu();
		t_incdec();
		t_logic();
		t_rot();
		t_bits();
		t_flow();
		t_skip();
		t_pcl();
		chk("options kept", OPTS, opt_v);
		give_verdict();
	end
endmodule // mcu_instruction_execution_timing_tb
`default_nettype wire
